// >>> rtl/lqm_cmp.sv
// Purpose: compares one adapted parameter against its high and low thresholds
// Assumes: parameter and thresholds are signed, same clock
// Notes:   rise pulses once per new violation so a held fault restarts only once
`timescale 1ns/1ns
`default_nettype none
module lqm_cmp (
    input  wire logic             clk_sys_in,    // system clock
    input  wire logic             rst_in,        // async reset, active high
    input  wire logic             active_in,     // monitor enabled with 100 Mb link
    input  wire logic [15:0]      param_in,      // adapted parameter value
    input  wire lqm_pkg::lqm_thr_t thr_in,       // thresholds
    output var lqm_pkg::lqm_flag_t flag_out,     // registered violation levels
    output logic                  rise_out       // pulse on a new violation
);
    lqm_pkg::lqm_flag_t next_flag;

    always_comb begin
        next_flag.hi = active_in && ($signed(param_in) > $signed(thr_in.hi));
        next_flag.lo = active_in && ($signed(param_in) < $signed(thr_in.lo));
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            flag_out <= '0;
        end else begin
            flag_out <= next_flag;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rise_out <= 1'b0;
        end else begin
            rise_out <= |(next_flag & ~flag_out);
        end
    end
endmodule : lqm_cmp
`default_nettype wire

// >>> rtl/lqm_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the link quality monitor
// Assumes: 32-bit classic wishbone, byte address = 4 * register index
// Notes:   constants only
// Behaviour
// (R1) A frequency-control violation with its restart control set resets the receive DSP and restarts adaptation.
// (R2) A frequency-offset violation with its restart control set resets the receive DSP and restarts adaptation.
// (R3) A baseline-wander violation with its restart control set resets the receive DSP and restarts adaptation.
// (R4) A digital-gain violation with its restart control set resets the receive DSP and restarts adaptation.
// (R5) An equalizer-coefficient violation with its restart control set resets the receive DSP and restarts adaptation.
// (R6) A restart taken while the signal-detect option is zero also drops the reported link status.
// (R7) Frequency-control high and low warnings sit at bits 9 and 8.
// (R8) Frequency-offset high and low warnings sit at bits 7 and 6.
// (R9) Baseline-wander high and low warnings sit at bits 5 and 4.
// (R10) Digital-gain high and low warnings sit at bits 3 and 2.
// (R11) Equalizer-coefficient high and low warnings sit at bits 1 and 0.
// (R12) Warnings are read-only, reset to zero and clear when the monitor register is read.
// (R13) Threshold writes are ignored while the device is powered down.
// (R14) The monitor works only while enabled and a valid 100 Mb link exists.
// (R15) A violation raises an interrupt if enabled, and a monitor register read re-arms it.
// (R16) A violation in the cycle of the clearing read keeps its warning bit set.
`ifndef LQM_MAP_SVH
`define LQM_MAP_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define LQM_IDX_CTRL      6'h1d
`define LQM_IDX_THR_BASE  6'h20
`define LQM_IDX_INT_STAT  6'h2a
`define LQM_IDX_INT_MASK  6'h2b
`define LQM_IDX_CONFIG    6'h2c

// ----------------------------------------
// fields
// ----------------------------------------
`define LQM_BIT_ENABLE    15
`define LQM_RESTART_LSB   10
`define LQM_WARN_MSB      9
`define LQM_BIT_SD_OPT    8
`define LQM_BIT_INT_EVT   0
`define LQM_NUM_PARAMS    5

// ----------------------------------------
// reset values
// ----------------------------------------
`define LQM_THR_HI_RST    16'h7fff
`define LQM_THR_LO_RST    16'h8000
`define LQM_CTRL_RST      6'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define LQM_CLK_MHZ       50
`define LQM_RESTART_NS    1000
`define LQM_RESTART_CYC   (((`LQM_RESTART_NS * `LQM_CLK_MHZ) + 999) / 1000)

`endif

// >>> rtl/lqm_pkg.sv
// Purpose: types shared by the link quality monitor modules
// Assumes: nothing
// Notes:   constants live in lqm_map.svh
package lqm_pkg;

    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
    } lqm_thr_t;

    typedef struct packed {
        logic hi;
        logic lo;
    } lqm_flag_t;

    typedef enum logic [0:0] {
        LQM_RS_IDLE   = 1'b0,
        LQM_RS_ACTIVE = 1'b1
    } lqm_rs_state_t;

endpackage : lqm_pkg

// >>> rtl/lqm_restart.sv
// Purpose: stretches a restart request into a DSP reset pulse and optional link drop
// Assumes: trigger is a one-cycle pulse
// Notes:   triggers during an active pulse are absorbed by it
`include "lqm_map.svh"
`timescale 1ns/1ns
`default_nettype none
module lqm_restart (
    input  wire logic clk_sys_in,     // system clock
    input  wire logic rst_in,         // async reset, active high
    input  wire logic trigger_in,     // restart request pulse
    input  wire logic signal_detect_option_in,   // signal-detect option
    output logic      dsp_reset_out,  // DSP reset and adaptation restart
    output logic      link_drop_out   // link status drop
);
    localparam logic [7:0] PULSE_CYC = 8'(`LQM_RESTART_CYC);

    lqm_pkg::lqm_rs_state_t state;
    logic [7:0]             count;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state <= lqm_pkg::LQM_RS_IDLE;
            count <= 8'h00;
        end else begin
            unique case (state)
                lqm_pkg::LQM_RS_IDLE: begin
                    if (trigger_in) begin
                        state <= lqm_pkg::LQM_RS_ACTIVE;
                        count <= PULSE_CYC - 8'h01;
                    end
                end
                lqm_pkg::LQM_RS_ACTIVE: begin
                    if (count == 8'h00) begin
                        state <= lqm_pkg::LQM_RS_IDLE;
                    end else begin
                        count <= count - 8'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            link_drop_out <= 1'b0;
        end else if (state == lqm_pkg::LQM_RS_IDLE) begin
            link_drop_out <= trigger_in && !signal_detect_option_in; // see (R6)
        end else if (count == 8'h00) begin
            // drop ends at the same edge as the DSP pulse
            link_drop_out <= 1'b0;
        end
    end

    assign dsp_reset_out = (state == lqm_pkg::LQM_RS_ACTIVE);
endmodule : lqm_restart
`default_nettype wire

// >>> rtl/lqm_top.sv
// Purpose: link quality monitor warnings, auto-restart and register file
// Assumes: parameters, link and power-down inputs come from logic on clk_sys_in
// Notes:   classic wishbone slave, one wait state, unmapped reads give zero
//
// Decided for this implementation: the Wishbone interface to the registers.
`include "lqm_map.svh"
`timescale 1ns/1ns
`default_nettype none
module lqm_top (
    input  wire logic        clk_sys_in,       // system clock, 50 MHz
    input  wire logic        rst_in,           // async reset, active high
    input  wire logic        wb_cyc_in,        // wishbone cycle
    input  wire logic        wb_stb_in,        // wishbone strobe
    input  wire logic        wb_we_in,         // wishbone write
    input  wire logic [7:0]  wb_adr_in,        // wishbone byte address
    input  wire logic [3:0]  wb_sel_in,        // wishbone byte enables
    input  wire logic [31:0] wb_dat_in,        // wishbone write data
    output logic      [31:0] wb_dat_out,       // wishbone read data
    output logic             wb_ack_out,       // wishbone acknowledge
    input  wire logic [15:0] eq_coeff_in,      // equalizer coefficient one
    input  wire logic [15:0] gain_in,          // digital gain
    input  wire logic [15:0] baseline_in,      // baseline wander
    input  wire logic [15:0] offset_in,        // frequency offset
    input  wire logic [15:0] freq_ctrl_in,     // frequency control
    input  wire logic        link_100_up_in,   // valid 100 Mb link
    input  wire logic        power_down_in,    // device powered down
    output logic             dsp_reset_out,    // receive DSP reset, adaptation restart
    output logic             link_drop_out,    // force link status down
    output logic             irq_out           // interrupt, level
);
    localparam int NP = `LQM_NUM_PARAMS;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wr,
                                             input logic [3:0] sel);
        merge16 = {sel[1] ? wr[15:8] : old_v[15:8], sel[0] ? wr[7:0] : old_v[7:0]};
    endfunction : merge16

    function automatic logic hit(input logic [5:0] idx, input logic [5:0] target);
        hit = (idx == target);
    endfunction : hit

    // ----------------------------------------
    // bus request
    // ----------------------------------------
    logic       req;
    logic       wr_req;
    logic       rd_req;
    logic [5:0] idx;

    assign req    = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wr_req = req && wb_we_in;
    assign rd_req = req && !wb_we_in;
    assign idx    = wb_adr_in[7:2];

    // ----------------------------------------
    // control and configuration
    // ----------------------------------------
    logic            mon_enable;
    logic [NP-1:0]   restart_on;
    logic            signal_detect_option;
    logic            active;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            {mon_enable, restart_on} <= `LQM_CTRL_RST;
        end else if (wr_req && hit(idx, `LQM_IDX_CTRL) && wb_sel_in[1]) begin
            // warning bits below are read-only, so only the high byte matters
            {mon_enable, restart_on} <= wb_dat_in[`LQM_BIT_ENABLE:`LQM_RESTART_LSB];
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            signal_detect_option <= 1'b0;
        end else if (wr_req && hit(idx, `LQM_IDX_CONFIG) && wb_sel_in[1]) begin
            signal_detect_option <= wb_dat_in[`LQM_BIT_SD_OPT];
        end
    end

    assign active = mon_enable && link_100_up_in; // see (R14)

    // ----------------------------------------
    // thresholds
    // ----------------------------------------
    lqm_pkg::lqm_thr_t thr [NP];

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            for (int k = 0; k < NP; k++) begin
                thr[k].hi <= `LQM_THR_HI_RST;
                thr[k].lo <= `LQM_THR_LO_RST;
            end
        end else if (wr_req && !power_down_in) begin // see (R13)
            for (int k = 0; k < NP; k++) begin
                if (hit(idx, `LQM_IDX_THR_BASE + 6'(2 * k))) begin
                    thr[k].lo <= merge16(thr[k].lo, wb_dat_in, wb_sel_in);
                end
                if (hit(idx, `LQM_IDX_THR_BASE + 6'(2 * k + 1))) begin
                    thr[k].hi <= merge16(thr[k].hi, wb_dat_in, wb_sel_in);
                end
            end
        end
    end

    // ----------------------------------------
    // comparators
    // ----------------------------------------
    logic [NP-1:0][15:0]        params;
    lqm_pkg::lqm_flag_t [NP-1:0] flags;
    logic [NP-1:0]              rise;

    assign params = {freq_ctrl_in, offset_in, baseline_in, gain_in, eq_coeff_in};

    for (genvar g = 0; g < NP; g++) begin : g_cmp
        lqm_cmp u_cmp (
            .clk_sys_in (clk_sys_in),
            .rst_in     (rst_in),
            .active_in  (active),
            .param_in   (params[g]),
            .thr_in     (thr[g]),
            .flag_out   (flags[g]),
            .rise_out   (rise[g])
        );
    end

    // ----------------------------------------
    // warnings
    // ----------------------------------------
    logic [`LQM_WARN_MSB:0] warn;
    logic                   ctrl_read;

    assign ctrl_read = rd_req && hit(idx, `LQM_IDX_CTRL);

    // flags pack as {fc, offset, baseline, gain, eq} x {hi, lo}
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            warn <= '0; // see (R12)
        end else begin
            // set beats the clearing read
            warn <= (ctrl_read ? '0 : warn) | flags; // see (R7) (R8) (R9) (R10) (R11) (R12) (R16)
        end
    end

    // ----------------------------------------
    // restart
    // ----------------------------------------
    logic restart_trigger;

    // index k of rise and restart_on name the same parameter
    assign restart_trigger = |(rise & restart_on); // see (R1) (R2) (R3) (R4) (R5)

    lqm_restart u_restart (
        .clk_sys_in    (clk_sys_in),
        .rst_in        (rst_in),
        .trigger_in    (restart_trigger),
        .signal_detect_option_in  (signal_detect_option),
        .dsp_reset_out (dsp_reset_out),
        .link_drop_out (link_drop_out)
    );

    // ----------------------------------------
    // interrupt
    // ----------------------------------------
    logic armed;
    logic int_stat;
    logic int_mask;
    logic int_event;

    // one event per arming keeps a chattering link from flooding software
    assign int_event = armed && (|rise); // see (R15)

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            armed <= 1'b1;
        end else if (ctrl_read) begin
            armed <= 1'b1; // see (R15)
        end else if (int_event) begin
            armed <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            int_stat <= 1'b0;
        end else if (int_event) begin
            int_stat <= 1'b1;
        end else if (wr_req && hit(idx, `LQM_IDX_INT_STAT) && wb_sel_in[0] && wb_dat_in[`LQM_BIT_INT_EVT]) begin
            int_stat <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            int_mask <= 1'b0;
        end else if (wr_req && hit(idx, `LQM_IDX_INT_MASK) && wb_sel_in[0]) begin
            int_mask <= wb_dat_in[`LQM_BIT_INT_EVT];
        end
    end

    assign irq_out = int_stat && int_mask;

    // ----------------------------------------
    // read data and acknowledge
    // ----------------------------------------
    logic [15:0] rd_mux;

    always_comb begin
        rd_mux = 16'h0000;
        if (hit(idx, `LQM_IDX_CTRL)) begin
            rd_mux = {mon_enable, restart_on, warn};
        end else if (hit(idx, `LQM_IDX_INT_STAT)) begin
            rd_mux = {15'h0000, int_stat};
        end else if (hit(idx, `LQM_IDX_INT_MASK)) begin
            rd_mux = {15'h0000, int_mask};
        end else if (hit(idx, `LQM_IDX_CONFIG)) begin
            rd_mux = {7'h00, signal_detect_option, 8'h00};
        end else begin
            for (int k = 0; k < NP; k++) begin
                if (hit(idx, `LQM_IDX_THR_BASE + 6'(2 * k))) begin
                    rd_mux = thr[k].lo;
                end
                if (hit(idx, `LQM_IDX_THR_BASE + 6'(2 * k + 1))) begin
                    rd_mux = thr[k].hi;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= req;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wb_dat_out <= 32'h0000_0000;
        end else if (rd_req) begin
            wb_dat_out <= {16'h0000, rd_mux};
        end
    end
endmodule : lqm_top
`default_nettype wire

// >>> tb/lqm_top_sva.sv
// Purpose: bus, restart and link-drop checks on lqm_top ports
// Assumes: single clock domain, async reset
// Notes:   bound into lqm_top below
`timescale 1ns/1ns
`default_nettype none
`include "lqm_map.svh"
module lqm_top_sva (
    input wire logic        clk_sys_in,     // clock
    input wire logic        rst_in,         // reset
    input wire logic        wb_cyc_in,      // cycle
    input wire logic        wb_stb_in,      // strobe
    input wire logic        wb_we_in,       // write
    input wire logic [7:0]  wb_adr_in,      // address
    input wire logic [31:0] wb_dat_out,     // read data
    input wire logic        wb_ack_out,     // ack
    input wire logic        link_100_up_in, // link
    input wire logic        dsp_reset_out,  // dsp reset
    input wire logic        link_drop_out   // link drop
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic [7:0] high_cnt;
    logic       unmapped;
    assign unmapped = (wb_adr_in[7:2] != 6'h1d) && ((wb_adr_in[7:2] < 6'h20) || (wb_adr_in[7:2] > 6'h2c));
    // saturates so a stuck pulse cannot wrap back into range
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            high_cnt <= 8'h00;
        end else if (!dsp_reset_out) begin
            high_cnt <= 8'h00;
        end else if (high_cnt != 8'hff) begin
            high_cnt <= high_cnt + 8'h01;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence s_req; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
    sequence s_ans; ##1 wb_ack_out ##1 !wb_ack_out; endsequence
    property p_ack_resp; s_req |-> s_ans; endproperty
    property p_ack_cause; $rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in); endproperty
    property p_upper_zero; wb_ack_out |-> wb_dat_out[31:16] == 16'h0000; endproperty
    property p_unmapped; wb_ack_out && $past(!wb_we_in && unmapped) |-> wb_dat_out == 32'h00000000; endproperty
    property p_dsp_len; $fell(dsp_reset_out) |-> high_cnt == `LQM_RESTART_CYC; endproperty
    property p_dsp_max; high_cnt <= `LQM_RESTART_CYC; endproperty
    property p_drop_in_dsp; link_drop_out |-> dsp_reset_out; endproperty
    property p_drop_rise; $rose(link_drop_out) |-> $rose(dsp_reset_out); endproperty
    property p_dsp_link; $rose(dsp_reset_out) |-> $past(link_100_up_in, 2); endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack not a single pulse");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_dsp_len: assert property (p_dsp_len) else $error("restart pulse length wrong");
    a_dsp_max: assert property (p_dsp_max) else $error("restart pulse too long");
    a_drop_in_dsp: assert property (p_drop_in_dsp) else $error("drop outside restart");
    a_drop_rise: assert property (p_drop_rise) else $error("drop not with restart");
    a_dsp_link: assert property (p_dsp_link) else $error("restart without link");
endmodule : lqm_top_sva
bind lqm_top lqm_top_sva i_lqm_sva (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .link_100_up_in(link_100_up_in), .dsp_reset_out(dsp_reset_out),
    .link_drop_out(link_drop_out));
`default_nettype wire

// >>> tb/lqm_top_test.sv
// Purpose: self-checking bench for lqm_top
// Assumes: one wait-state wishbone slave
// Notes:   after the blocking time-zero setup, drives are non-blocking at rising edges
`timescale 1ns/1ns
`default_nettype none
`include "lqm_map.svh"
module lqm_top_test;
    logic             clk_sys_in, rst_in, cyc, stb, we, ack, link, pd, dsp, drop, irq;
    logic [3:0]       sel;
    logic [7:0]       adr;
    logic [31:0]      wdat, rdat;
    logic [4:0][15:0] par;
    int               err_total, comparisons;
    localparam logic [7:0] CTRL = 8'h74, ISTAT = 8'ha8, IMASK = 8'hac, CFG = 8'hb0;

    lqm_top i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .eq_coeff_in(par[0]), .gain_in(par[1]), .baseline_in(par[2]),
        .offset_in(par[3]), .freq_ctrl_in(par[4]), .link_100_up_in(link), .power_down_in(pd),
        .dsp_reset_out(dsp), .link_drop_out(drop), .irq_out(irq));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'h3;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        check(32'(n < 20), 32'h1);
        cyc <= 1'b0; stb <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask : rd
    function automatic logic [7:0] thr(input int k, input logic h);
        return 8'h80 + 8'(8 * k) + (h ? 8'h04 : 8'h00);
    endfunction : thr
    // one violation of a few cycles, then back inside the window
    task automatic pulse(input int k, input logic [15:0] v);
        @(posedge clk_sys_in);
        par[k] <= v;
        repeat (2) @(posedge clk_sys_in);
        par[k] <= 16'h0000;
        repeat (3) @(posedge clk_sys_in);
    endtask : pulse

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(CTRL, 32'h0);
        for (int k = 0; k < 5; k++) begin
            rd(thr(k, 1'b1), 32'h7fff);
            rd(thr(k, 1'b0), 32'h8000);
        end
        rd(ISTAT, 32'h0);
        wr(8'hfc, 32'hffff);
        rd(8'hfc, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_warn;
        wr(CTRL, 32'h83ff);
        rd(CTRL, 32'h8000);
        for (int k = 0; k < 5; k++) begin
            wr(thr(k, 1'b1), 32'h0100);
            wr(thr(k, 1'b0), 32'hff00);
            pulse(k, 16'h0200);
            rd(CTRL, 32'h8000 | (32'h1 << (2 * k + 1)));
            pulse(k, 16'hfe00);
            rd(CTRL, 32'h8000 | (32'h1 << (2 * k)));
            rd(CTRL, 32'h8000);
            check(32'(dsp), 32'h0);
        end
        $display("test warn done");
    endtask : t_warn
    task automatic t_power;
        @(posedge clk_sys_in);
        pd <= 1'b1;
        wr(thr(0, 1'b1), 32'h0050);
        rd(thr(0, 1'b1), 32'h0100);
        pd <= 1'b0;
        wr(thr(0, 1'b1), 32'h0050);
        rd(thr(0, 1'b1), 32'h0050);
        wr(thr(0, 1'b1), 32'h0100);
        $display("test power done");
    endtask : t_power
    task automatic t_restart;
        int n, m;
        for (int k = 0; k < 5; k++) begin
            wr(CFG, 32'(k % 2) << 8);
            rd(CFG, 32'(k % 2) << 8);
            wr(CTRL, 32'h8000 | (32'h1 << (10 + k)));
            @(posedge clk_sys_in);
            par[k] <= 16'h0200;
            n = 0;
            do begin
                @(posedge clk_sys_in);
                n++;
            end while (dsp !== 1'b1 && n < 10);
            par[k] <= 16'h0000;
            check(32'(n >= 2 && n <= 5), 32'h1);
            check(32'(drop), 32'((k % 2) == 0));
            m = 0;
            while (dsp === 1'b1 && m < 100) begin
                m++;
                @(posedge clk_sys_in);
            end
            check(32'(m), `LQM_RESTART_CYC);
            rd(CTRL, 32'h8000 | (32'h1 << (10 + k)) | (32'h1 << (2 * k + 1)));
        end
        $display("test restart done");
    endtask : t_restart
    task automatic t_irq;
        wr(CTRL, 32'h8000);
        wr(IMASK, 32'h0);
        wr(ISTAT, 32'h1);
        rd(ISTAT, 32'h0);
        rd(CTRL, 32'h8000);
        pulse(0, 16'h0200);
        rd(ISTAT, 32'h1);
        check(32'(irq), 32'h0);
        wr(IMASK, 32'h1);
        rd(IMASK, 32'h1);
        check(32'(irq), 32'h1);
        wr(ISTAT, 32'h1);
        check(32'(irq), 32'h0);
        pulse(0, 16'h0200);
        rd(ISTAT, 32'h0);
        rd(CTRL, 32'h8002);
        pulse(0, 16'h0200);
        check(32'(irq), 32'h1);
        $display("test irq done");
    endtask : t_irq
    task automatic t_idle;
        rd(CTRL, 32'h8002);
        // violation flag meets the clearing read at the same edge
        @(posedge clk_sys_in);
        par[0] <= 16'h0200;
        fork
            rd(CTRL, 32'h8000);
            begin
                @(posedge clk_sys_in);
                par[0] <= 16'h0000;
            end
        join
        rd(CTRL, 32'h8002);
        @(posedge clk_sys_in);
        link <= 1'b0;
        pulse(1, 16'h0200);
        rd(CTRL, 32'h8000);
        link <= 1'b1;
        wr(CTRL, 32'h0);
        pulse(1, 16'h0200);
        rd(CTRL, 32'h0);
        $display("test idle done");
    endtask : t_idle

    // ----------------------------------------
    // run
    // ----------------------------------------
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        err_total++;
        results();
    end
    initial begin
        rst_in = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; sel = 4'h0;
        adr = 8'h00; wdat = 32'h0; par = '0; link = 1'b1; pd = 1'b0;
        err_total = 0; comparisons = 0;
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        t_reset();
        t_warn();
        t_power();
        t_restart();
        t_irq();
        t_idle();
        results();
    end
endmodule : lqm_top_test
`default_nettype wire
